// [core/rsc_pkg.sv]
// Shared constants of the radio state-control link: register map, codes, timing.
// Assumes both ends and the bench import it; no logic lives here.
package rsc_pkg;
  // Device register offsets on the link.
  localparam logic [5:0] ADDR_STATUS = 6'h01;
  localparam logic [5:0] ADDR_STATE = 6'h02;
  localparam logic [5:0] ADDR_CTRL1 = 6'h04;
  localparam logic [5:0] ADDR_CCA_CTRL = 6'h08;
  localparam logic [5:0] ADDR_CCA_THR = 6'h09;
  localparam logic [5:0] ADDR_AACK_CTRL = 6'h17;
  localparam logic [5:0] ADDR_FILT_LO = 6'h20;
  localparam logic [5:0] ADDR_RETRY = 6'h2c;
  localparam logic [5:0] ADDR_SEED_LO = 6'h2d;
  localparam logic [5:0] ADDR_SEED_HI = 6'h2e;
  localparam logic [5:0] ADDR_BE = 6'h2f;
  localparam logic [5:0] ADDR_ABORT_CHK = 6'h32;
  // Reset values.
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [7:0] RST_STATE = 8'h00;
  localparam logic [7:0] RST_CTRL1 = 8'h20;
  localparam logic [7:0] RST_RETRY = 8'h38;
  localparam logic [7:0] RST_CFG = 8'h00;
  // Field positions.
  localparam int SLOT_BIT = 0;
  localparam int RES_LSB = 5;
  // State codes.
  localparam logic [4:0] ST_P_ON = 5'h00;
  localparam logic [4:0] ST_BUSY_RX = 5'h01;
  localparam logic [4:0] ST_BUSY_TX = 5'h02;
  localparam logic [4:0] ST_RX_ON = 5'h06;
  localparam logic [4:0] ST_OFF = 5'h08;
  localparam logic [4:0] ST_PLL_ON = 5'h09;
  localparam logic [4:0] ST_SLEEP = 5'h0f;
  localparam logic [4:0] ST_BUSY_AACK = 5'h11;
  localparam logic [4:0] ST_BUSY_ARET = 5'h12;
  localparam logic [4:0] ST_AACK_ON = 5'h16;
  localparam logic [4:0] ST_ARET_ON = 5'h19;
  localparam logic [4:0] ST_RX_NOCLK = 5'h1c;
  localparam logic [4:0] ST_AACK_NOCLK = 5'h1d;
  localparam logic [4:0] ST_BUSY_AACK_NOCLK = 5'h1e;
  localparam logic [4:0] ST_TRANS = 5'h1f;
  // State commands.
  localparam logic [4:0] CMD_NOP = 5'h00;
  localparam logic [4:0] CMD_TX_START = 5'h02;
  localparam logic [4:0] CMD_FORCE_OFF = 5'h03;
  localparam logic [4:0] CMD_FORCE_PLL = 5'h04;
  localparam logic [4:0] CMD_RX_ON = 5'h06;
  localparam logic [4:0] CMD_OFF = 5'h08;
  localparam logic [4:0] CMD_PLL_ON = 5'h09;
  localparam logic [4:0] CMD_AACK = 5'h16;
  localparam logic [4:0] CMD_ARET = 5'h19;
  // Transaction results.
  localparam logic [2:0] RES_SUCCESS = 3'h0;
  localparam logic [2:0] RES_PENDING = 3'h1;
  localparam logic [2:0] RES_AWAIT_ACK = 3'h2;
  localparam logic [2:0] RES_CHAN_FAIL = 3'h3;
  localparam logic [2:0] RES_NO_ACK = 3'h5;
  localparam logic [2:0] RES_INVALID = 3'h7;
  // Timing: state transition settling time.
  localparam int CLK_NS = 40;
  localparam int TRANS_NS = 1000;
  localparam logic [5:0] TRANS_CYC = 6'((TRANS_NS + CLK_NS - 1) / CLK_NS);
  // Host APB register offsets and fields.
  localparam logic [7:0] HOFS_CMD = 8'h00;
  localparam logic [7:0] HOFS_STAT = 8'h04;
  localparam logic [7:0] HOFS_PIN = 8'h08;
  localparam int CMD_ADDR_LSB = 8;
  localparam int CMD_WE_BIT = 16;
  localparam int STAT_BUSY_BIT = 8;
  localparam int STAT_FE_BIT = 9;
  localparam int STAT_AM_BIT = 10;
  localparam int STAT_GATE_BIT = 11;
  // Host sequencer states, Gray coded.
  typedef enum logic [1:0] {H_IDLE = 2'b00, H_WAIT = 2'b01} rsc_hst_t;
endpackage : rsc_pkg

// [core/rsc_link_if.sv]
// Link between the host controller and the radio state-control device.
// Assumes one shared clock; both ends drive their outputs from flip-flops.
`timescale 1ns/1ps
interface rsc_link_if;
  logic req;
  logic we;
  logic [5:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic ack;
  logic sleep_transmit_pin;
  logic frame_end_irq;
  logic address_match_irq;
  logic [3:0] other_irq;
  modport dev(input req, input we, input addr, input wdata, input sleep_transmit_pin,
    output rdata, output ack, output frame_end_irq, output address_match_irq,
    output other_irq);
  modport host(output req, output we, output addr, output wdata, output sleep_transmit_pin,
    input rdata, input ack, input frame_end_irq, input address_match_irq,
    input other_irq);
endinterface : rsc_link_if

// [core/rsc_device.sv]
// Radio state-control device end: register bank, state codes, transaction results
// and frame interrupts. Assumes the radio engine reports events as one-cycle pulses
// on the clk domain, and the host holds req until ack.
// Notes on behaviour
// - Auto-retry raises frame end once, at end
// - Acknowledge frames raise no match/end interrupt in extended (AACK) receive
// - Basic interrupt sources stay available
// - Status read-only; assessment bits frozen extended
// - Basic state codes reported as encoded
// - Extended state codes, transition code 0x1F
// - Host waits out transition before commanding
// - Sleep state hides all registers
// - Command field write starts transition
// - Host confirms transition via status read
// - Result field read-only, command bits writable
// - Result encodings per transaction kind
// - Result resets zero, procedure start sets seven
// - Pending-bit acknowledge reports result one
// - Slotted ready acknowledge reports two, pin launches
// - Command encodings; other values do nothing
// - Forced PLL-on refused from low states
// - Host checks 0x32 before forced PLL-on
// - Extended configuration at fixed addresses
// - Start command or pin edge starts retry
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
module rsc_device (
  input wire logic clk,
  input wire logic arst_n,
  rsc_link_if.dev lnk,
  input wire logic ev_tx_end,
  input wire logic ev_ack_req,
  input wire logic ev_ack_rx,
  input wire logic ev_ack_pend,
  input wire logic ev_cca_fail,
  input wire logic ev_no_ack,
  input wire logic ev_rx_start,
  input wire logic ev_rx_end,
  input wire logic ev_is_ack,
  input wire logic ev_addr_match,
  input wire logic ev_assessment_done_flag,
  input wire logic ev_cca_clear,
  input wire logic [3:0] ev_other,
  output logic [7:0] retry_cfg,
  output logic [7:0] backoff_cfg
);
  import rsc_pkg::*;

  logic [4:0] state_q, state_d, target_q, target_d, cmdf_q;
  logic [5:0] tcnt_q;
  logic tload;
  logic [2:0] result_q, result_d;
  logic done_q, clear_q, pin_q, ack_q, fe_q, fe_d, am_q, am_d;
  logic [7:0] rdata_q, rdata_d;
  logic [3:0] other_q;
  logic [7:0] cfg_q [0:19];
  logic acc, wr, rd_status, sleeping, ext, cmd_wr, pin_rise, pin_fall, fpll_ok, slotted;
  logic cfg_hit;
  logic [4:0] cfg_sel, cmd;

  // One access per request; the ack flop blocks a second take of a held request.
  assign acc = lnk.req & ~ack_q;
  assign sleeping = (state_q == ST_SLEEP);
  assign wr = acc & lnk.we & ~sleeping;
  assign rd_status = acc & ~lnk.we & ~sleeping & (lnk.addr == ADDR_STATUS);
  assign cmd_wr = wr & (lnk.addr == ADDR_STATE);
  assign cmd = lnk.wdata[4:0];
  assign pin_rise = lnk.sleep_transmit_pin & ~pin_q;
  assign pin_fall = ~lnk.sleep_transmit_pin & pin_q;
  assign slotted = cfg_q[12][SLOT_BIT];
  assign ext = (state_q == ST_BUSY_AACK) || (state_q == ST_BUSY_ARET) ||
               (state_q == ST_AACK_ON) || (state_q == ST_ARET_ON) ||
               (state_q == ST_AACK_NOCLK) || (state_q == ST_BUSY_AACK_NOCLK);
  assign fpll_ok = !((state_q == ST_SLEEP) || (state_q == ST_P_ON) || (state_q == ST_OFF) ||
                     (state_q == ST_RX_NOCLK) || (state_q == ST_AACK_NOCLK) ||
                     (state_q == ST_BUSY_AACK_NOCLK) ||
                     ((state_q == ST_TRANS) && ((target_q == ST_OFF) ||
                      (target_q == ST_SLEEP) || (target_q == ST_P_ON))));

  // Configuration decode: 0x20..0x2f map to entries 0..15, the four others above.
  // fixed configuration map.
  always_comb begin
    cfg_hit = 1'b1;
    cfg_sel = 5'h00;
    if (lnk.addr >= ADDR_FILT_LO && lnk.addr <= ADDR_BE) begin
      cfg_sel = {1'b0, lnk.addr[3:0]};
    end else if (lnk.addr == ADDR_CTRL1) begin
      cfg_sel = 5'h10;
    end else if (lnk.addr == ADDR_CCA_CTRL) begin
      cfg_sel = 5'h11;
    end else if (lnk.addr == ADDR_CCA_THR) begin
      cfg_sel = 5'h12;
    end else if (lnk.addr == ADDR_AACK_CTRL) begin
      cfg_sel = 5'h13;
    end else begin
      cfg_hit = 1'b0;
    end
  end

  // Configuration storage, one flop byte per entry.
  for (genvar i = 0; i < 20; i++) begin : g_cfg
    localparam logic [7:0] RV = (i == 12) ? RST_RETRY : ((i == 16) ? RST_CTRL1 : RST_CFG);
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        cfg_q[i] <= RV;
      end else if (wr && cfg_hit && cfg_sel == 5'(i)) begin
        cfg_q[i] <= lnk.wdata;
      end
    end
  end

  // State, result and interrupt next values. Commands outrank pin and engine events.
  always_comb begin
    state_d = state_q;
    target_d = target_q;
    tload = 1'b0;
    result_d = result_q;
    fe_d = 1'b0;
    am_d = 1'b0;
    if (cmd_wr) begin
      case (cmd)
        CMD_TX_START: begin
          if (state_q == ST_PLL_ON) begin
            state_d = ST_BUSY_TX;
          end else if (state_q == ST_ARET_ON) begin
            state_d = ST_BUSY_ARET;
            result_d = RES_INVALID;
          end
        end
        CMD_FORCE_OFF: begin
          state_d = ST_OFF;
        end
        CMD_FORCE_PLL: begin
          if (fpll_ok) begin
            state_d = ST_PLL_ON;
          end
        end
        CMD_RX_ON, CMD_OFF, CMD_PLL_ON, CMD_AACK, CMD_ARET: begin
          if (state_q != ST_TRANS && state_q != cmd) begin
            state_d = ST_TRANS;
            target_d = cmd;
            tload = 1'b1;
            if (cmd == CMD_AACK || cmd == CMD_ARET) begin
              result_d = RES_INVALID;
            end
          end
        end
        default: begin
        end
      endcase
    end else begin
      case (state_q)
        ST_TRANS: begin
          if (tcnt_q == 6'h00) begin
            state_d = target_q;
          end
        end
        ST_OFF: begin
          if (pin_rise) begin
            state_d = ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          if (pin_fall) begin
            state_d = ST_TRANS;
            target_d = ST_OFF;
            tload = 1'b1;
          end
        end
        ST_PLL_ON: begin
          if (pin_rise) begin
            state_d = ST_BUSY_TX;
          end
        end
        ST_ARET_ON: begin
          if (pin_rise) begin
            state_d = ST_BUSY_ARET;
            result_d = RES_INVALID;
          end
        end
        ST_BUSY_TX: begin
          if (ev_tx_end) begin
            fe_d = 1'b1;
            state_d = ST_PLL_ON;
          end
        end
        ST_BUSY_ARET: begin
          state_d = ST_ARET_ON;
          fe_d = 1'b1;
          if (ev_cca_fail) begin
            result_d = RES_CHAN_FAIL;
          end else if (ev_no_ack) begin
            result_d = RES_NO_ACK;
          end else if (ev_ack_rx) begin
            result_d = ev_ack_pend ? RES_PENDING : RES_SUCCESS;
          end else if (ev_tx_end && !ev_ack_req) begin
            result_d = RES_SUCCESS;
          end else begin
            state_d = ST_BUSY_ARET;
            fe_d = 1'b0;
          end
        end
        ST_RX_ON: begin
          if (ev_rx_start) begin
            state_d = ST_BUSY_RX;
          end
        end
        ST_BUSY_RX: begin
          am_d = ev_addr_match;
          if (ev_rx_end) begin
            fe_d = 1'b1;
            state_d = ST_RX_ON;
          end
        end
        ST_AACK_ON: begin
          if (ev_rx_start) begin
            state_d = ST_BUSY_AACK;
            result_d = RES_INVALID;
          end
        end
        ST_BUSY_AACK: begin
          if (result_q == RES_AWAIT_ACK) begin
            if (pin_rise) begin
              result_d = RES_SUCCESS;
              state_d = ST_AACK_ON;
            end
          end else begin
            am_d = ev_addr_match & ~ev_is_ack;
            if (ev_rx_end && ev_is_ack) begin
              state_d = ST_AACK_ON;
            end else if (ev_rx_end) begin
              fe_d = 1'b1;
              if (slotted && ev_ack_req) begin
                result_d = RES_AWAIT_ACK;
              end else begin
                result_d = RES_SUCCESS;
                state_d = ST_AACK_ON;
              end
            end
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_P_ON;
      target_q <= ST_P_ON;
      tcnt_q <= 6'h00;
    end else begin
      state_q <= state_d;
      target_q <= target_d;
      if (tload) begin
        tcnt_q <= TRANS_CYC - 6'h01;
      end else if (tcnt_q != 6'h00) begin
        tcnt_q <= tcnt_q - 6'h01;
      end
    end
  end

  // result held apart from command bits.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      result_q <= RST_STATE[7:RES_LSB];
      cmdf_q <= RST_STATE[4:0];
    end else begin
      result_q <= result_d;
      if (cmd_wr) begin
        cmdf_q <= cmd;
      end
    end
  end

  // Assessment flags; a new result outranks the clear that a status read makes.
  // frozen in extended mode.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      done_q <= RST_STATUS[7];
      clear_q <= RST_STATUS[6];
    end else if (ev_assessment_done_flag && !ext) begin
      done_q <= 1'b1;
      clear_q <= ev_cca_clear;
    end else if (rd_status) begin
      done_q <= 1'b0;
    end
  end

  // Read data mux; asleep everything reads zero.
  // reserved bit reads zero.
  always_comb begin
    rdata_d = 8'h00;
    if (!sleeping) begin
      if (lnk.addr == ADDR_STATUS) begin
        rdata_d = {done_q, clear_q, 1'b0, state_q};
      end else if (lnk.addr == ADDR_STATE) begin
        rdata_d = {result_q, cmdf_q};
      end else if (cfg_hit) begin
        rdata_d = cfg_q[cfg_sel];
      end
    end
  end

  // Link answer, pin edge history and interrupt pulses.
  // other sources passed through.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_q <= 1'b0;
      rdata_q <= 8'h00;
      pin_q <= 1'b0;
      fe_q <= 1'b0;
      am_q <= 1'b0;
      other_q <= 4'h0;
    end else begin
      ack_q <= acc;
      if (acc) begin
        rdata_q <= rdata_d;
      end
      pin_q <= lnk.sleep_transmit_pin;
      fe_q <= fe_d;
      am_q <= am_d;
      other_q <= ev_other;
    end
  end

  assign lnk.ack = ack_q;
  assign lnk.rdata = rdata_q;
  assign lnk.frame_end_irq = fe_q;
  assign lnk.address_match_irq = am_q;
  assign lnk.other_irq = other_q;
  assign retry_cfg = cfg_q[12];
  assign backoff_cfg = cfg_q[15];
endmodule : rsc_device

// [core/rsc_host.sv]
// Host controller end: takes register orders over APB and runs them on the link.
// Assumes the device shares clk and answers each held request with one ack pulse.
`timescale 1ns/1ps
module rsc_host (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic slot_boundary,
  rsc_link_if.host lnk
);
  import rsc_pkg::*;

  rsc_hst_t hst_q;
  logic pready_q, pslverr_q, req_q, we_q, gate_q, fpll_ok_q, fe_q, am_q;
  logic lvl_q, pend_q, pin_q;
  logic [5:0] addr_q;
  logic [7:0] wdata_q, rd_q;
  logic [31:0] prdata_q;
  logic go, commit, cmd_acc, refuse, launch, fire, stat_wr;
  logic [5:0] new_addr;

  // Two-cycle APB access: the first access cycle computes, the second completes.
  assign go = psel & penable & ~pready_q;
  assign commit = psel & penable & pready_q;
  assign new_addr = pwdata[CMD_ADDR_LSB +: 6];
  assign cmd_acc = pwrite & (paddr == HOFS_CMD);
  assign refuse = (hst_q != H_IDLE) |
                  (pwdata[CMD_WE_BIT] & (new_addr == ADDR_STATE) &
                   (gate_q | ((pwdata[4:0] == CMD_FORCE_PLL) & ~fpll_ok_q)));
  assign launch = commit & cmd_acc & ~pslverr_q;
  assign stat_wr = commit & pwrite & (paddr == HOFS_STAT);
  assign fire = pend_q & slot_boundary;

  // APB answer.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= go;
      pslverr_q <= go & cmd_acc & refuse;
      if (go) begin
        case (paddr)
          HOFS_CMD: prdata_q <= {15'h0000, we_q, 2'b00, addr_q, wdata_q};
          HOFS_STAT: prdata_q <= {20'h00000, gate_q, am_q, fe_q, hst_q != H_IDLE, rd_q};
          HOFS_PIN: prdata_q <= {30'h0000_0000, pend_q, lvl_q};
          default: prdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Link sequencer: hold the request until the device acks it.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hst_q <= H_IDLE;
      req_q <= 1'b0;
      we_q <= 1'b0;
      addr_q <= 6'h00;
      wdata_q <= 8'h00;
      rd_q <= 8'h00;
    end else begin
      case (hst_q)
        H_IDLE: begin
          if (launch) begin
            hst_q <= H_WAIT;
            req_q <= 1'b1;
            we_q <= pwdata[CMD_WE_BIT];
            addr_q <= new_addr;
            wdata_q <= pwdata[7:0];
          end
        end
        H_WAIT: begin
          if (lnk.ack) begin
            hst_q <= H_IDLE;
            req_q <= 1'b0;
            if (!we_q) begin
              rd_q <= lnk.rdata;
            end
          end
        end
        default: hst_q <= H_IDLE;
      endcase
    end
  end

  // Command gate: set by a state command, cleared by a stable status read.
  // confirm by status read.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gate_q <= 1'b0;
      fpll_ok_q <= 1'b0;
    end else begin
      if (launch && pwdata[CMD_WE_BIT] && new_addr == ADDR_STATE) begin
        gate_q <= 1'b1;
        fpll_ok_q <= 1'b0;
      end else if (hst_q == H_WAIT && lnk.ack && !we_q) begin
        if (addr_q == ADDR_STATUS && lnk.rdata[4:0] != ST_TRANS) begin
          gate_q <= 1'b0;
        end
        if (addr_q == ADDR_ABORT_CHK) begin
          fpll_ok_q <= (lnk.rdata[7:RES_LSB] == 3'h0);
        end
      end
    end
  end

  // Sticky interrupt seen flags; a new pulse wins over a write-one clear.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fe_q <= 1'b0;
      am_q <= 1'b0;
    end else begin
      fe_q <= lnk.frame_end_irq | (fe_q & ~(stat_wr & pwdata[STAT_FE_BIT]));
      am_q <= lnk.address_match_irq | (am_q & ~(stat_wr & pwdata[STAT_AM_BIT]));
    end
  end

  // Sleep/transmit pin: a level plus one-cycle pulses timed to the slot boundary.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lvl_q <= 1'b0;
      pend_q <= 1'b0;
      pin_q <= 1'b0;
    end else begin
      if (commit && pwrite && paddr == HOFS_PIN) begin
        lvl_q <= pwdata[0];
        pend_q <= pwdata[1];
      end else if (fire) begin
        pend_q <= 1'b0;
      end
      pin_q <= lvl_q | fire;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign lnk.req = req_q;
  assign lnk.we = we_q;
  assign lnk.addr = addr_q;
  assign lnk.wdata = wdata_q;
  assign lnk.sleep_transmit_pin = pin_q;
endmodule : rsc_host

// [sim/rsc_link_properties.sv]
// Checker of the link between the host end and the device end.
// Assumes one clock domain; its inputs mirror the link signals.
`timescale 1ns/1ps
module rsc_link_properties (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic req,
  input wire logic we,
  input wire logic [5:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic ack,
  input wire logic frame_end_irq,
  input wire logic address_match_irq
);
  import rsc_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Register reads are judged in the ack cycle, where read data is valid.
  wire logic rd_st = ack && !we && addr == ADDR_STATUS;
  wire logic rd_tr = ack && !we && addr == ADDR_STATE;
  sequence s_ans;
    ack ##1 (!ack && !req);
  endsequence
  property p_ans;
    $rose(req) |=> s_ans;
  endproperty
  a_ans: assert property (p_ans) else $error("late answer");
  property p_hold;
    req && !ack |=> req && $stable(addr) && $stable(wdata) && $stable(we);
  endproperty
  a_hold: assert property (p_hold) else $error("request moved");
  property p_ack;
    ack |-> req;
  endproperty
  a_ack: assert property (p_ack) else $error("stray ack");
  property p_resv;
    rd_st |-> !rdata[5];
  endproperty
  a_resv: assert property (p_resv) else $error("reserved bit set");
  property p_code;
    rd_st |-> rdata[4:0] inside {5'h00, 5'h01, 5'h02, 5'h06, 5'h08, 5'h09, 5'h0f,
      5'h11, 5'h12, 5'h16, 5'h19, 5'h1c, 5'h1d, 5'h1e, 5'h1f};
  endproperty
  a_code: assert property (p_code) else $error("reserved code");
  property p_res;
    rd_tr |-> rdata[7:5] inside {3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h7};
  endproperty
  a_res: assert property (p_res) else $error("reserved result");
  property p_fe;
    frame_end_irq |=> !frame_end_irq [*2];
  endproperty
  a_fe: assert property (p_fe) else $error("repeated frame end");
  property p_am;
    address_match_irq |=> !address_match_irq;
  endproperty
  a_am: assert property (p_am) else $error("long match pulse");
endmodule : rsc_link_properties

// [sim/radio_state_control_status_bench.sv]
// Bench joining host end and device end; drives APB and radio events.
// Assumes the host answers APB and polls are bounded by the cycle ceiling.
`timescale 1ns/1ps
module radio_state_control_status_bench;
  import rsc_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic slot_boundary = 1'b0;
  logic [11:0] ev = 12'h000;
  logic [3:0] ev_other = 4'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] retry_cfg;
  logic [7:0] backoff_cfg;
  logic [7:0] r;
  logic [31:0] s;
  logic perr;
  int err_total = 0;
  int checks = 0;
  int cyc = 0;
  rsc_link_if link();
  rsc_host rsc_host_inst (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .slot_boundary(slot_boundary), .lnk(link.host));
  rsc_device rsc_device_inst (.clk(clk), .arst_n(arst_n), .lnk(link.dev),
    .ev_tx_end(ev[0]), .ev_ack_req(ev[1]), .ev_ack_rx(ev[2]), .ev_ack_pend(ev[3]),
    .ev_cca_fail(ev[4]), .ev_no_ack(ev[5]), .ev_rx_start(ev[6]), .ev_rx_end(ev[7]),
    .ev_is_ack(ev[8]), .ev_addr_match(ev[9]), .ev_assessment_done_flag(ev[10]),
    .ev_cca_clear(ev[11]), .ev_other(ev_other), .retry_cfg(retry_cfg),
    .backoff_cfg(backoff_cfg));
  rsc_link_properties props (.clk(clk), .arst_n(arst_n), .req(link.req), .we(link.we),
    .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata), .ack(link.ack),
    .frame_end_irq(link.frame_end_irq), .address_match_irq(link.address_match_irq));
  task automatic conclude();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask : chk
  // One APB transfer; an idle cycle follows so psel never changes twice at one edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    s = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  // Device access through the command word, then poll until the link is idle.
  task automatic dop(input logic w, input logic [5:0] a, input logic [7:0] d);
    apb(1'b1, HOFS_CMD, {15'h0, w, 2'h0, a, d});
    s = 32'h100;
    while (s[STAT_BUSY_BIT] !== 1'b0) apb(1'b0, HOFS_STAT, 32'h0);
    r = s[7:0];
  endtask : dop
  task automatic cmd(input logic [4:0] c);
    dop(1'b1, ADDR_STATE, {3'h0, c});
    r = 8'h1f;
    while (r[4:0] === ST_TRANS) dop(1'b0, ADDR_STATUS, 8'h00);
  endtask : cmd
  task automatic pu(input logic [11:0] m);
    ev <= m;
    @(posedge clk);
    ev <= 12'h000;
    @(posedge clk);
  endtask : pu
  task automatic t_reset();
    dop(1'b0, ADDR_STATUS, 8'h00);
    chk("status", RST_STATUS, r);
    dop(1'b0, ADDR_STATE, 8'h00);
    chk("state", RST_STATE, r);
    dop(1'b0, ADDR_CTRL1, 8'h00);
    chk("ctrl1", RST_CTRL1, r);
    chk("retry", RST_RETRY, retry_cfg);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 8'h00, s[7:0]);
  endtask : t_reset
  task automatic t_states();
    logic [4:0] c[5] = '{CMD_PLL_ON, CMD_RX_ON, CMD_OFF, CMD_AACK, CMD_ARET};
    logic [4:0] e[5] = '{ST_PLL_ON, ST_RX_ON, ST_OFF, ST_AACK_ON, ST_ARET_ON};
    for (int i = 0; i < 5; i++) begin
      cmd(c[i]);
      chk("code", {3'h0, e[i]}, r);
      if (i == 2) begin
        dop(1'b1, ADDR_RETRY, RST_RETRY | 8'h01);
        dop(1'b1, ADDR_BE, 8'h5a);
        chk("backoff", 8'h5a, backoff_cfg);
      end
    end
    dop(1'b1, ADDR_STATE, 8'h05);
    dop(1'b0, ADDR_STATUS, 8'h00);
    chk("reserved cmd", {3'h0, ST_ARET_ON}, r);
  endtask : t_states
  task automatic t_aret();
    logic [11:0] p[4] = '{12'h003, 12'h000, 12'h003, 12'h003};
    logic [11:0] m[4] = '{12'h00c, 12'h010, 12'h020, 12'h004};
    logic [2:0] e[4] = '{RES_PENDING, RES_CHAN_FAIL, RES_NO_ACK, RES_SUCCESS};
    for (int i = 0; i < 4; i++) begin
      dop(1'b1, ADDR_STATE, {3'h0, CMD_TX_START});
      dop(1'b0, ADDR_STATUS, 8'h00);
      chk("busy code", {3'h0, ST_BUSY_ARET}, r);
      dop(1'b0, ADDR_STATE, 8'h00);
      chk("start res", {RES_INVALID, 5'h0}, {r[7:5], 5'h0});
      pu(p[i]);
      apb(1'b0, HOFS_STAT, 32'h0);
      chk("early end", 8'h00, {7'h0, s[STAT_FE_BIT]});
      pu(m[i]);
      dop(1'b0, ADDR_STATUS, 8'h00);
      chk("end code", {3'h0, ST_ARET_ON}, r);
      chk("end seen", 8'h01, {7'h0, s[STAT_FE_BIT]});
      apb(1'b1, HOFS_STAT, 32'h200);
      dop(1'b0, ADDR_STATE, 8'h00);
      chk("result", {e[i], 5'h0}, {r[7:5], 5'h0});
    end
    dop(1'b1, ADDR_STATE, 8'he0);
    dop(1'b0, ADDR_STATE, 8'h00);
    chk("result ro", {RES_SUCCESS, 5'h0}, {r[7:5], 5'h0});
    // A second state command before the status read must be refused.
    apb(1'b1, HOFS_CMD, {15'h0, 1'b1, 2'h0, ADDR_STATE, 3'h0, CMD_NOP});
    chk("refused", 8'h01, {7'h0, perr});
    dop(1'b0, ADDR_STATUS, 8'h00);
    chk("after nop", {3'h0, ST_ARET_ON}, r);
  endtask : t_aret
  task automatic t_aack();
    cmd(CMD_AACK);
    // Each frame opens with a receive start so the device leaves its listen state.
    pu(12'h040);
    pu(12'h380);
    pu(12'hc00);
    dop(1'b0, ADDR_STATUS, 8'h00);
    chk("cca frozen", {3'h0, ST_AACK_ON}, r);
    chk("ack irqs", 8'h00, {6'h0, s[STAT_AM_BIT], s[STAT_FE_BIT]});
    pu(12'h040);
    pu(12'h280);
    apb(1'b0, HOFS_STAT, 32'h0);
    chk("data irqs", 8'h03, {6'h0, s[STAT_AM_BIT], s[STAT_FE_BIT]});
    ev_other <= 4'ha;
    @(posedge clk);
    ev_other <= 4'h0;
    @(posedge clk);
    chk("other", 8'h0a, {4'h0, link.other_irq});
    pu(12'h040);
    pu(12'h082);
    dop(1'b0, ADDR_STATE, 8'h00);
    chk("slot wait", {RES_AWAIT_ACK, 5'h0}, {r[7:5], 5'h0});
    apb(1'b1, HOFS_PIN, 32'h2);
    slot_boundary <= 1'b1;
    @(posedge clk);
    slot_boundary <= 1'b0;
    dop(1'b0, ADDR_STATE, 8'h00);
    chk("slot sent", {RES_SUCCESS, 5'h0}, {r[7:5], 5'h0});
  endtask : t_aack
  task automatic t_low();
    cmd(CMD_FORCE_OFF);
    dop(1'b0, ADDR_ABORT_CHK, 8'h00);
    dop(1'b1, ADDR_STATE, {3'h0, CMD_FORCE_PLL});
    dop(1'b0, ADDR_STATUS, 8'h00);
    chk("no force", {3'h0, ST_OFF}, r);
    apb(1'b1, HOFS_PIN, 32'h1);
    dop(1'b0, ADDR_BE, 8'h00);
    chk("sleep hides", 8'h00, r);
  endtask : t_low
  initial begin
    forever #20 clk = ~clk;
  end
  // Cycle ceiling cuts a hang short and counts it as a mismatch.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      conclude();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_states();
    t_aret();
    t_aack();
    t_low();
    conclude();
  end
endmodule : radio_state_control_status_bench
